// ==== src/ebsw_defs.vh ====
`ifndef EBSW_DEFS_VH
`define EBSW_DEFS_VH

// APB register byte addresses
`define EBSW_BSC_ADDR 32'hFFFFF480
`define EBSW_DWC_ADDR 32'hFFFFF484
`define EBSW_STAT_ADDR 32'hFFFFF490

// Reset values
`define EBSW_BSC_RST 16'h5555
`define EBSW_DWC_RST 16'h7777

// Field positions
`define EBSW_DWC_CS0_LSB 0
`define EBSW_DWC_CS1_LSB 4
`define EBSW_BSC_CS0_BIT 0
`define EBSW_BSC_CS1_BIT 2

// Address map, 26-bit linear space
`define EBSW_CS0_PAGE 10'h010
`define EBSW_CS1_PAGE 10'h020
`define EBSW_ROM_TOP 26'h0100000
`define EBSW_RAM_BASE 26'h3FF0000
`define EBSW_PERI_BASE 26'h3FFF000

// Access kinds and sizes
`define EBSW_KIND_SEQ 2'h0
`define EBSW_KIND_BR 2'h1
`define EBSW_KIND_OP 2'h2
`define EBSW_SZ_BYTE 2'h0
`define EBSW_SZ_HALF 2'h1
`define EBSW_SZ_WORD 2'h2

// Access costs in bus clocks
`define EBSW_ROM_SEQ 3'h1
`define EBSW_ROM_BR 3'h2
`define EBSW_ROM_OP 3'h3
`define EBSW_RAM_SEQ 3'h1
`define EBSW_RAM_BR 3'h2
`define EBSW_RAM_OP 3'h1
`define EBSW_PERI_CYC 3'h3

`endif

// ==== src/ebsw_ctrl.v ====
`include "ebsw_defs.vh"

// Function
// R1: First chip select only in first window
// R2: Second chip select only in second window
// R3: Fixed access costs per area and kind
// R4: RAM fetch conflicting with data: one extra
// R5: Per-area 8/16-bit width, reset 5555H
// R6: Software configures once before external use
// R7: Software writes fixed bus-size bit values
// R8: Peripheral path always 16 bits wide
// R9: Little endian, lowest part first
// R10: Unaligned accesses split, never fault
// R11: Odd halfword: two byte cycles
// R12: Odd word: byte, halfword, byte
// R13: Word at binary 10: two halfwords
// R14: Per-area wait count 0 to 7
// R15: Wait fields bits 2:0 and 6:4
// R16: Seven waits everywhere after reset; code applies 7 only in the two chip-select windows, 0 elsewhere
// R17: Software writes zero to reserved wait bits
// R18: No programmed or pin waits internally
// R19: Wait pin stretches cycle without limit
// R20: Wait pin sampled at clock fall, T2/TW
// R21: Programmed and pin waits ORed
// R22: No hold grant between split cycles
// R23: Chip selects idle outside windows, internally
// R24: Even bytes low lanes, odd high lanes
module ebsw_ctrl (
  input wire pclk,
  input wire presetn,
  input wire [31:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire req_valid,
  output wire req_ready,
  input wire [25:0] req_addr,
  input wire [1:0] req_size,
  input wire [1:0] req_kind,
  input wire req_write,
  input wire [31:0] req_wdata,
  input wire req_conflict,
  input wire periph_wait_req,
  input wire [31:0] int_rdata,
  output reg resp_valid,
  output reg [31:0] resp_rdata,
  output wire system_clock_output,
  output wire [15:0] ad_o,
  output wire ad_oe,
  input wire [15:0] ad_i,
  input wire wait_n,
  output wire chip_select_first_n,
  output wire chip_select_second_n,
  output wire astb,
  output wire rd_n,
  output wire [1:0] wr_n,
  input wire hold_req_n,
  output wire hold_ack_n
);

  localparam S_IDLE = 6'h01;
  localparam S_INT = 6'h02;
  localparam S_T1 = 6'h04;
  localparam S_T2 = 6'h08;
  localparam S_TW = 6'h10;
  localparam S_T3 = 6'h20;

  reg [15:0] bsc_ff;
  reg [15:0] dwc_ff;
  reg [5:0] st_ff;
  reg ph_ff;
  reg clk_ff;
  reg [25:0] cur_ff;
  reg [1:0] base_ff;
  reg [2:0] left_ff;
  reg w16_ff;
  reg peri_ff;
  reg [1:0] csel_ff;
  reg write_ff;
  reg [31:0] wdata_ff;
  reg [31:0] rdata_ff;
  reg [2:0] cnt_ff;
  reg [2:0] wcnt_ff;
  reg wsmp_ff;
  reg hold_ff;
  reg wait_s1_ff;
  reg wait_s2_ff;
  reg hold_s1_ff;
  reg hold_s2_ff;
  reg [15:0] ad_s1_ff;
  reg [15:0] ad_s2_ff;

  reg [5:0] nxt_st;
  reg [25:0] nxt_cur;
  reg [2:0] nxt_left;
  reg [2:0] nxt_cnt;
  reg [2:0] nxt_wcnt;
  reg [31:0] nxt_rdata;
  reg nxt_resp;
  reg [31:0] nxt_resp_rdata;
  reg [2:0] cost;
  reg [2:0] req_bytes;
  integer i;

  wire apb_wr = psel & penable & pwrite;
  wire in_cs0 = req_addr[25:16] == `EBSW_CS0_PAGE; // R1
  wire in_cs1 = req_addr[25:16] == `EBSW_CS1_PAGE; // R2
  wire req_rom = req_addr < `EBSW_ROM_TOP;
  wire req_peri = req_addr >= `EBSW_PERI_BASE;
  wire req_ram = (req_addr >= `EBSW_RAM_BASE) & ~req_peri;
  wire req_ext = ~req_rom & ~req_ram & ~req_peri;
  wire req_bus16 = in_cs0 ? bsc_ff[`EBSW_BSC_CS0_BIT] :
                   in_cs1 ? bsc_ff[`EBSW_BSC_CS1_BIT] : 1'b1; // R5
  wire [2:0] req_wait = in_cs0 ? dwc_ff[`EBSW_DWC_CS0_LSB +: 3] :
                        in_cs1 ? dwc_ff[`EBSW_DWC_CS1_LSB +: 3] : 3'h0; // R14 R15 R16
  wire hold_rq = ~hold_s2_ff;
  wire idle_end = (st_ff == S_IDLE) & ph_ff;
  wire ext_go = req_ext | req_peri;
  // Hold blocks external and peripheral requests; internal memory runs on
  assign req_ready = idle_end & ~((hold_ff | hold_rq) & ext_go);
  wire take = req_valid & req_ready;
  wire ext_state = (st_ff == S_T1) | (st_ff == S_T2) | (st_ff == S_TW) | (st_ff == S_T3);

  // Piece size: byte on an 8-bit bus, on odd addresses, or as the last byte
  wire [2:0] psz = (~w16_ff | cur_ff[0] | (left_ff == 3'h1)) ? 3'h1 : 3'h2; // R10 R11 R12 R13
  wire [1:0] boff = cur_ff[1:0] - base_ff;
  wire [31:0] wsh = wdata_ff >> {boff, 3'b000};
  wire upper = w16_ff & cur_ff[0]; // R24
  wire last_piece = left_ff == psz;

  assign pready = 1'b1;
  assign system_clock_output = clk_ff;
  assign hold_ack_n = ~hold_ff;
  assign chip_select_first_n = ~(ext_state & csel_ff[0]); // R1 R23
  assign chip_select_second_n = ~(ext_state & csel_ff[1]); // R2 R23
  assign astb = st_ff == S_T1;
  assign ad_oe = ext_state & ((st_ff == S_T1) | write_ff);
  assign ad_o = (st_ff == S_T1) ? cur_ff[15:0] :
                (psz == 3'h2) ? wsh[15:0] : {wsh[7:0], wsh[7:0]}; // R24
  assign rd_n = ~(~write_ff & ((st_ff == S_T2) | (st_ff == S_TW) | (st_ff == S_T3)));
  assign wr_n[0] = ~(write_ff & ~st_ff[0] & ~astb & ext_state & ~upper);
  assign wr_n[1] = ~(write_ff & ext_state & ~astb & (upper | (psz == 3'h2)));

  always @*
  begin
    case (req_size)
      `EBSW_SZ_BYTE: req_bytes = 3'h1;
      `EBSW_SZ_HALF: req_bytes = 3'h2;
      default: req_bytes = 3'h4;
    endcase
    if (req_peri)
      cost = `EBSW_PERI_CYC; // R3
    else if (req_rom)
      cost = (req_kind == `EBSW_KIND_SEQ) ? `EBSW_ROM_SEQ :
             (req_kind == `EBSW_KIND_BR) ? `EBSW_ROM_BR : `EBSW_ROM_OP; // R3
    else
      cost = ((req_kind == `EBSW_KIND_SEQ) ? `EBSW_RAM_SEQ :
              (req_kind == `EBSW_KIND_BR) ? `EBSW_RAM_BR : `EBSW_RAM_OP) +
             {2'b00, req_conflict & (req_kind != `EBSW_KIND_OP)}; // R3 R4
  end

  always @*
  begin
    nxt_st = st_ff;
    nxt_cur = cur_ff;
    nxt_left = left_ff;
    nxt_cnt = cnt_ff;
    nxt_wcnt = wcnt_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = 1'b0;
    nxt_resp_rdata = resp_rdata;
    // Lanes of this piece land at their byte offset, lowest first
    for (i = 0; i < 4; i = i + 1)
    begin
      if ((st_ff == S_T3) & ~write_ff & (i == boff))
        nxt_rdata[8 * i +: 8] = upper ? ad_s2_ff[15:8] : ad_s2_ff[7:0]; // R9 R24
      if ((st_ff == S_T3) & ~write_ff & (psz == 3'h2) & (i == boff + 1))
        nxt_rdata[8 * i +: 8] = ad_s2_ff[15:8]; // R24
    end
    if (ph_ff)
    begin
      case (st_ff)
        S_IDLE:
        begin
          if (take)
          begin
            nxt_cur = req_addr;
            nxt_left = req_bytes;
            nxt_cnt = cost - 3'h1;
            nxt_wcnt = req_wait;
            nxt_rdata = 32'h00000000;
            nxt_st = req_ext ? S_T1 : S_INT;
          end
        end
        S_INT:
        begin
          // Peripherals stretch only by their own wait request
          if ((cnt_ff != 3'h0) | (peri_ff & periph_wait_req)) // R18
            nxt_cnt = (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
          else if (peri_ff & ~last_piece)
          begin
            nxt_cur = cur_ff + {23'h000000, psz};
            nxt_left = left_ff - psz;
            nxt_cnt = `EBSW_PERI_CYC - 3'h1; // R3 R8
          end
          else
          begin
            nxt_st = S_IDLE;
            nxt_resp = 1'b1;
            nxt_resp_rdata = int_rdata;
          end
        end
        S_T1: nxt_st = S_T2;
        S_T2, S_TW:
        begin
          if ((wcnt_ff != 3'h0) | wsmp_ff) // R19 R21
          begin
            nxt_st = S_TW;
            nxt_wcnt = (wcnt_ff != 3'h0) ? wcnt_ff - 3'h1 : 3'h0; // R14
          end
          else
            nxt_st = S_T3;
        end
        S_T3:
        begin
          if (last_piece)
          begin
            nxt_st = S_IDLE;
            nxt_resp = 1'b1;
            nxt_resp_rdata = nxt_rdata;
          end
          else
          begin
            // Straight to the next piece, never via idle, so hold waits
            nxt_st = S_T1; // R22
            nxt_cur = cur_ff + {23'h000000, psz}; // R9
            nxt_left = left_ff - psz;
            nxt_wcnt = csel_ff[0] ? dwc_ff[`EBSW_DWC_CS0_LSB +: 3] :
                       csel_ff[1] ? dwc_ff[`EBSW_DWC_CS1_LSB +: 3] : 3'h0;
          end
        end
        default: nxt_st = S_IDLE;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= S_IDLE;
      ph_ff <= 1'b0;
      clk_ff <= 1'b1;
      cur_ff <= 26'h0000000;
      base_ff <= 2'h0;
      left_ff <= 3'h0;
      w16_ff <= 1'b1;
      peri_ff <= 1'b0;
      csel_ff <= 2'h0;
      write_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
      cnt_ff <= 3'h0;
      wcnt_ff <= 3'h0;
      wsmp_ff <= 1'b0;
      hold_ff <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h00000000;
    end
    else
    begin
      // Bus clock is pclk/2; each bus state spans one full period
      ph_ff <= ~ph_ff;
      clk_ff <= ph_ff;
      st_ff <= nxt_st;
      cur_ff <= nxt_cur;
      left_ff <= nxt_left;
      cnt_ff <= nxt_cnt;
      wcnt_ff <= nxt_wcnt;
      rdata_ff <= nxt_rdata;
      resp_valid <= nxt_resp;
      resp_rdata <= nxt_resp_rdata;
      if (take)
      begin
        base_ff <= req_addr[1:0];
        w16_ff <= req_bus16 | req_peri; // R8
        peri_ff <= req_peri;
        csel_ff <= {in_cs1, in_cs0};
        write_ff <= req_write;
        wdata_ff <= req_wdata;
      end
      // Pin sampled where the bus clock falls; no sample outside T2/TW
      if (~ph_ff & ((st_ff == S_T2) | (st_ff == S_TW)))
        wsmp_ff <= ~wait_s2_ff; // R20
      else if (~ph_ff)
        wsmp_ff <= 1'b0; // R18
      if (idle_end & ~take)
        hold_ff <= hold_rq; // R22
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_s1_ff <= 1'b1;
      wait_s2_ff <= 1'b1;
      hold_s1_ff <= 1'b1;
      hold_s2_ff <= 1'b1;
      ad_s1_ff <= 16'h0000;
      ad_s2_ff <= 16'h0000;
    end
    else
    begin
      wait_s1_ff <= wait_n;
      wait_s2_ff <= wait_s1_ff;
      hold_s1_ff <= hold_req_n;
      hold_s2_ff <= hold_s1_ff;
      ad_s1_ff <= ad_i;
      ad_s2_ff <= ad_s1_ff;
    end
  end

  // Written values are applied as given; fixed-bit discipline is software's
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bsc_ff <= `EBSW_BSC_RST; // R5
      dwc_ff <= `EBSW_DWC_RST; // R16
    end
    else
    begin
      if (apb_wr & (paddr == `EBSW_BSC_ADDR))
        bsc_ff <= pwdata[15:0]; // R7
      else if (apb_wr & (paddr == `EBSW_DWC_ADDR))
        dwc_ff <= pwdata[15:0]; // R17
    end
  end

  always @*
  begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (paddr == `EBSW_BSC_ADDR)
      prdata = {16'h0000, bsc_ff};
    else if (paddr == `EBSW_DWC_ADDR)
      prdata = {16'h0000, dwc_ff};
    else if (paddr == `EBSW_STAT_ADDR)
      prdata = {16'h0000, 2'b00, st_ff, 6'h00, hold_ff, ~(st_ff == S_IDLE)};
    else
      pslverr = psel & penable;
  end

endmodule

// ==== test/ebsw_asserts.sv ====
`include "ebsw_defs.vh"
module ebsw_asserts (
  input wire pclk,
  input wire presetn,
  input wire req_valid,
  input wire req_ready,
  input wire [25:0] req_addr,
  input wire [1:0] req_kind,
  input wire req_conflict,
  input wire resp_valid,
  input wire wait_n,
  input wire rd_n,
  input wire chip_select_first_n,
  input wire chip_select_second_n,
  input wire hold_ack_n,
  input wire ad_oe,
  input wire [1:0] wr_n,
  input wire system_clock_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire tk = req_valid && req_ready;
  wire [9:0] pg = req_addr[25:16];
  wire rom = req_addr < `EBSW_ROM_TOP && req_kind != `EBSW_KIND_OP;
  wire ram = req_addr >= `EBSW_RAM_BASE && req_addr < `EBSW_PERI_BASE;
  wire br = req_kind == `EBSW_KIND_BR;
  property p_sel1_in;
    tk && pg == 10'h010 |=> !chip_select_first_n [*6];
  endproperty
  a_sel1_in: assert property (p_sel1_in) else $error("first select missing");
  property p_sel1_out;
    tk && pg != 10'h010 |=> chip_select_first_n [*2];
  endproperty
  a_sel1_out: assert property (p_sel1_out) else $error("first select stray");
  property p_sel2_in;
    tk && pg == 10'h020 |=> !chip_select_second_n [*6];
  endproperty
  a_sel2_in: assert property (p_sel2_in) else $error("second select missing");
  property p_int_sel;
    tk && rom |=> (chip_select_first_n && chip_select_second_n) [*2];
  endproperty
  a_int_sel: assert property (p_int_sel) else $error("select on internal");
  property p_rom_br;
    tk && rom && br |-> ##4 !resp_valid ##1 resp_valid;
  endproperty
  a_rom_br: assert property (p_rom_br) else $error("rom branch cost");
  property p_ram_cf;
    tk && ram && br && req_conflict |-> ##6 !resp_valid ##1 resp_valid;
  endproperty
  a_ram_cf: assert property (p_ram_cf) else $error("ram conflict cost");
  property p_wait;
    (!rd_n && !wait_n) [*8] |=> !rd_n;
  endproperty
  a_wait: assert property (p_wait) else $error("wait pin ignored");
  property p_hold;
    !chip_select_first_n || !chip_select_second_n |-> hold_ack_n;
  endproperty
  a_hold: assert property (p_hold) else $error("hold in cycle");
  property p_read_float;
    !rd_n |-> !ad_oe;
  endproperty
  a_read_float: assert property (p_read_float) else $error("bus driven in read");
  property p_write_drive;
    wr_n != 2'h3 |-> ad_oe;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("bus idle in write");
  property p_clk_out;
    system_clock_output |=> !system_clock_output;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output stuck");
endmodule
bind ebsw_ctrl ebsw_asserts u_chk (.*);

// ==== test/ebsw_mem.sv ====
module ebsw_mem (
  input wire pclk,
  input wire lclk,
  input wire stall,
  input wire [15:0] ad_o,
  input wire astb,
  input wire rd_n,
  input wire [1:0] wr_n,
  input wire chip_select_second_n,
  output logic [15:0] ad_i = '0,
  output logic wait_n = 1'b1,
  output logic [7:0] pieces_ff = '0,
  output logic [15:0] wdat_ff = '0,
  output logic [1:0] wlane_ff = '0,
  output logic [15:0] last_a_ff = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic astb_ff = 1'b0;
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  always @(posedge pclk)
  begin
    astb_ff <= astb;
    if (astb && !astb_ff)
    begin
      last_a_ff <= ad_o;
      pieces_ff <= pieces_ff + 8'h01;
    end
    if (wr_n != 2'h3)
    begin
      wlane_ff <= wr_n;
      wdat_ff <= ad_o;
    end
    // Released bus toggles so stale data never looks valid
    ad_i <= ~ad_i;
    if (!rd_n && !chip_select_second_n)
      ad_i <= {~ad_i[15:8], byte_at(last_a_ff)};
    else if (!rd_n)
      ad_i <= {byte_at(last_a_ff | 16'h0001), byte_at(last_a_ff & 16'hFFFE)};
  end
  always @(posedge lclk)
    wait_n <= !stall;
endmodule

// ==== test/tb_external_bus_sizing_and_waits.sv ====
`include "ebsw_defs.vh"
module tb_external_bus_sizing_and_waits;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, lclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_conflict = 1'b0, cf = 1'b0, stall = 1'b0, serr;
  logic hold_req_n = 1'b1, periph_wait_req = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, req_wdata = '0, int_rdata = 32'hC0DE1234, rd, rdat;
  logic [25:0] req_addr = '0;
  logic [1:0] req_size = '0, req_kind = '0;
  wire [31:0] prdata, resp_rdata;
  wire [15:0] ad_o, ad_i, wdat_ff, last_a_ff;
  wire [7:0] pieces_ff;
  wire [1:0] wr_n, wlane_ff;
  wire pready, pslverr, req_ready, resp_valid, system_clock_output, ad_oe, wait_n, hold_ack_n;
  wire chip_select_first_n, chip_select_second_n, astb, rd_n;
  int errors = 0, checks_done = 0, cyc = 0, ncyc;
  ebsw_ctrl dut (.*);
  ebsw_mem mem (.*);
  initial forever #12.5 pclk = ~pclk;
  initial
  begin
    #37;
    forever #100 lclk = ~lclk;
  end
  function automatic logic [7:0] dat(input int a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task acc(input logic [25:0] a, input logic [1:0] sz, k, input logic w, input logic [31:0] d, input int e);
    @(posedge pclk);
    req_addr <= a;
    req_size <= sz;
    req_kind <= k;
    req_write <= w;
    req_wdata <= d;
    req_conflict <= cf;
    req_valid <= 1'b1;
    @(negedge pclk);
    while (req_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    req_valid <= 1'b0;
    @(negedge pclk);
    for (ncyc = 1; ncyc < 300 && resp_valid !== 1'b1; ncyc++) @(negedge pclk);
    rd = resp_rdata;
    chk("response", resp_valid, 1'b1);
    if (e > 0) chk("cycles", ncyc, e);
  endtask
  task piece(input logic [25:0] a, input logic [1:0] sz, input int np, e, input logic [31:0] x,
    input logic [15:0] la);
    logic [7:0] p0;
    p0 = pieces_ff;
    acc(a, sz, `EBSW_KIND_OP, 1'b0, '0, e);
    chk("pieces", pieces_ff - p0, np);
    chk("data", rd & (sz == `EBSW_SZ_WORD ? 32'hFFFFFFFF : 32'h0000FFFF), x);
    chk("last piece", last_a_ff, la);
  endtask
  task t_regs;
    apb(1'b0, 32'hFFFFF480, '0);
    chk("size reg", rdat, 32'h00005555);
    apb(1'b0, 32'hFFFFF484, '0);
    chk("wait reg", rdat, 32'h00007777);
    apb(1'b0, 32'hFFFFF4A0, '0);
    chk("unmapped", serr, 1'b1);
    apb(1'b1, 32'hFFFFF480, 32'h00005551);
    apb(1'b1, 32'hFFFFF484, 32'h00000007);
    apb(1'b0, 32'hFFFFF484, '0);
    chk("wait reg", rdat, 32'h00000007);
    acc(26'h0100000, `EBSW_SZ_BYTE, `EBSW_KIND_OP, 1'b0, '0, 21);
    chk("byte", rd[7:0], dat(0));
  endtask
  task t_split;
    piece(26'h0100003, `EBSW_SZ_WORD, 3, 61, {dat(6), dat(5), dat(4), dat(3)}, 16'h0006);
    piece(26'h0100001, `EBSW_SZ_HALF, 2, 41, {16'h0000, dat(2), dat(1)}, 16'h0002);
    piece(26'h0100002, `EBSW_SZ_WORD, 2, 41, {dat(5), dat(4), dat(3), dat(2)}, 16'h0004);
    piece(26'h0200001, `EBSW_SZ_WORD, 4, 25, {dat(4), dat(3), dat(2), dat(1)}, 16'h0004);
  endtask
  task t_write;
    acc(26'h0100005, `EBSW_SZ_BYTE, `EBSW_KIND_OP, 1'b1, 32'h0000003C, 21);
    chk("lanes", wlane_ff, 2'h1);
    chk("wdata", wdat_ff[15:8], 8'h3C);
    acc(26'h0200003, `EBSW_SZ_BYTE, `EBSW_KIND_OP, 1'b1, 32'h000000C3, 7);
    chk("lanes", wlane_ff, 2'h2);
    chk("wdata", wdat_ff[7:0], 8'hC3);
  endtask
  task t_wait;
    stall = 1'b1;
    repeat (20) @(posedge pclk);
    fork
      begin
        repeat (80) @(posedge pclk);
        stall = 1'b0;
      end
    join_none
    acc(26'h0200000, `EBSW_SZ_BYTE, `EBSW_KIND_OP, 1'b0, '0, 0);
    chk("stretched", ncyc > 40, 1'b1);
    chk("byte", rd[7:0], dat(0));
  endtask
  task t_int;
    stall = 1'b1;
    repeat (20) @(posedge pclk);
    acc(26'h0001000, `EBSW_SZ_WORD, `EBSW_KIND_SEQ, 1'b0, '0, 3);
    acc(26'h0001000, `EBSW_SZ_WORD, `EBSW_KIND_BR, 1'b0, '0, 5);
    acc(26'h0001000, `EBSW_SZ_WORD, `EBSW_KIND_OP, 1'b0, '0, 7);
    chk("int data", rd, int_rdata);
    acc(`EBSW_RAM_BASE, `EBSW_SZ_WORD, `EBSW_KIND_SEQ, 1'b0, '0, 3);
    acc(`EBSW_RAM_BASE, `EBSW_SZ_WORD, `EBSW_KIND_OP, 1'b0, '0, 3);
    cf = 1'b1;
    acc(`EBSW_RAM_BASE, `EBSW_SZ_WORD, `EBSW_KIND_BR, 1'b0, '0, 7);
    cf = 1'b0;
    acc(`EBSW_PERI_BASE, `EBSW_SZ_HALF, `EBSW_KIND_OP, 1'b0, '0, 7);
    acc(`EBSW_PERI_BASE, `EBSW_SZ_WORD, `EBSW_KIND_OP, 1'b0, '0, 13);
    @(posedge pclk);
    periph_wait_req <= 1'b1;
    fork
      begin
        repeat (12) @(posedge pclk);
        periph_wait_req <= 1'b0;
      end
    join_none
    acc(`EBSW_PERI_BASE, `EBSW_SZ_HALF, `EBSW_KIND_OP, 1'b0, '0, 0);
    chk("peri stretch", ncyc > 8, 1'b1);
    stall = 1'b0;
  endtask
  task t_hold;
    fork
      begin
        repeat (6) @(posedge pclk);
        hold_req_n <= 1'b0;
      end
    join_none
    // Hold raised mid-access must not stretch or split it
    piece(26'h0200001, `EBSW_SZ_WORD, 4, 25, {dat(4), dat(3), dat(2), dat(1)}, 16'h0004);
    repeat (8) @(negedge pclk);
    chk("hold grant", hold_ack_n, 1'b0);
    apb(1'b0, `EBSW_STAT_ADDR, '0);
    chk("status", rdat, 32'h00000102);
    acc(26'h0001000, `EBSW_SZ_WORD, `EBSW_KIND_SEQ, 1'b0, '0, 3);
    @(posedge pclk);
    hold_req_n <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("hold free", hold_ack_n, 1'b1);
  endtask
  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, `EBSW_DWC_ADDR, '0);
    chk("wait reg", rdat, 32'h00007777);
    acc(26'h0200000, `EBSW_SZ_BYTE, `EBSW_KIND_OP, 1'b0, '0, 21);
    chk("byte", rd[7:0], dat(0));
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs;
    t_split;
    t_write;
    t_hold;
    t_wait;
    t_int;
    t_reset;
    report_and_stop;
  end
endmodule
